// file: logic/sco_pkg.sv
// Shared constants, types and helpers for the strap override configuration block.
package sco_pkg;

    // Management bus command code of the override word.
    localparam logic [7:0]  SCO_CMD_OVERRIDE = 8'hd8;

    // Bit positions inside the override word.
    localparam int SCO_POS_GLOBAL  = 15;
    localparam int SCO_POS_SS      = 11;
    localparam int SCO_POS_FAULT   = 10;
    localparam int SCO_POS_ADDR    = 9;
    localparam int SCO_POS_MODE    = 6;
    localparam int SCO_POS_FSW     = 5;
    localparam int SCO_POS_RAMP    = 4;
    localparam int SCO_POS_GAIN    = 3;
    localparam int SCO_POS_OCL     = 2;
    localparam int SCO_POS_VOLTAGE_SELECT_STRAP    = 0;

    // Bits that can hold a one; every other bit reads as zero.
    localparam logic [15:0] SCO_WR_MASK    = 16'h8e7d;
    // Override word and outputs before the first restore.
    localparam logic [15:0] SCO_WORD_RESET = 16'h0000;

    // Index of each function in the selection and written vectors.
    localparam int SCO_NFUNC   = 9;
    localparam int SCO_F_SS    = 0;
    localparam int SCO_F_FAULT = 1;
    localparam int SCO_F_ADDR  = 2;
    localparam int SCO_F_MODE  = 3;
    localparam int SCO_F_FSW   = 4;
    localparam int SCO_F_RAMP  = 5;
    localparam int SCO_F_GAIN  = 6;
    localparam int SCO_F_OCL   = 7;
    localparam int SCO_F_VOLTAGE_SELECT_STRAP  = 8;

    // Boot DAC target in units of 1/4096 V, indexed by the 5-bit boot code.
    localparam logic [11:0] SCO_BOOT_DAC_TBL [32] = '{
        12'h000, 12'h4cc, 12'h500, 12'h534, 12'h568, 12'h59a, 12'h5cc, 12'h600,
        12'h634, 12'h666, 12'h69a, 12'h6cc, 12'h700, 12'h734, 12'h768, 12'h79a,
        12'h7cc, 12'h800, 12'h834, 12'h866, 12'h898, 12'h8cc, 12'h900, 12'h934,
        12'h968, 12'h998, 12'ha00, 12'ha66, 12'hacc, 12'hb34, 12'hb98, 12'hc00};

    // Power-up sequencing states, one-hot.
    typedef enum logic [1:0] {
        SCO_ST_WAIT = 2'b01,
        SCO_ST_RUN  = 2'b10
    } sco_state_t;

    // One setting per overridable function, from strap or from stored memory.
    typedef struct packed {
        logic [3:0] ton_rise;
        logic [1:0] fault_resp;
        logic [6:0] bus_addr;
        logic       light_load;
        logic [1:0] fsw;
        logic [1:0] ramp;
        logic [2:0] gain;
        logic [1:0] ocl;
        logic [4:0] boot_voltage_code;
    } sco_func_t;

    // Keeps only the bits of the override word that exist.
    function automatic logic [15:0] sco_keep_bits(input logic [15:0] w);
        sco_keep_bits = w & SCO_WR_MASK;
    endfunction : sco_keep_bits

endpackage : sco_pkg

// file: logic/sco_boot_decode.sv
// Boot voltage code to reference DAC target lookup.
`timescale 1ns/1ps
`default_nettype none
module sco_boot_decode
    import sco_pkg::*;
(
    // Code in, target out.
    input  wire logic [4:0]  boot_voltage_code,
    output logic      [11:0] boot_dac_voltage
);

    // Fixed table; code 5'h1f gives the highest target.
    assign boot_dac_voltage = SCO_BOOT_DAC_TBL[boot_voltage_code]; // [RULE16]

endmodule : sco_boot_decode
`default_nettype wire

// file: logic/sco_select.sv
// Per-function choice between strap results and stored values.
`timescale 1ns/1ps
`default_nettype none
module sco_select
    import sco_pkg::*;
(
    // Steering inputs.
    input  wire logic [15:0]          ovr_word,
    input  wire logic [SCO_NFUNC-1:0] written,
    input  wire logic                 ext_divider,
    // Candidate values.
    input  wire sco_func_t            strap_val,
    input  wire sco_func_t            nvm_val,
    // Result.
    output sco_func_t                 sel_val,
    output logic      [SCO_NFUNC-1:0] use_strap
);

    logic [SCO_NFUNC-1:0] bypass;

    // Per-function bypass bits in function order.
    assign bypass = {ovr_word[SCO_POS_VOLTAGE_SELECT_STRAP], ovr_word[SCO_POS_OCL], ovr_word[SCO_POS_GAIN],
                     ovr_word[SCO_POS_RAMP], ovr_word[SCO_POS_FSW], ovr_word[SCO_POS_MODE],
                     ovr_word[SCO_POS_ADDR], ovr_word[SCO_POS_FAULT], ovr_word[SCO_POS_SS]};

    // Strap wins by default; a bypass bit or the global bit hands over to the stored
    // value, and once the host rewrites a function the stored side holds its new value.
    always_comb begin
        use_strap = '0;
        for (int i = 0; i < SCO_NFUNC; i++) begin
            use_strap[i] = !ovr_word[SCO_POS_GLOBAL] && !bypass[i] && !written[i]; // [RULE1] [RULE2] [RULE4]
        end
        // An external divider never takes the voltage selection from the strap.
        use_strap[SCO_F_VOLTAGE_SELECT_STRAP] = use_strap[SCO_F_VOLTAGE_SELECT_STRAP] && !ext_divider; // [RULE14]
    end

    // Field multiplexers.
    always_comb begin
        sel_val = nvm_val;
        if (use_strap[SCO_F_SS]) begin
            sel_val.ton_rise = strap_val.ton_rise; // [RULE6]
        end
        if (use_strap[SCO_F_FAULT]) begin
            sel_val.fault_resp = strap_val.fault_resp; // [RULE7]
        end
        if (use_strap[SCO_F_ADDR]) begin
            sel_val.bus_addr = strap_val.bus_addr; // [RULE8]
        end
        if (use_strap[SCO_F_MODE]) begin
            sel_val.light_load = strap_val.light_load; // [RULE9]
        end
        if (use_strap[SCO_F_FSW]) begin
            sel_val.fsw = strap_val.fsw; // [RULE10]
        end
        if (use_strap[SCO_F_RAMP]) begin
            sel_val.ramp = strap_val.ramp; // [RULE11]
        end
        if (use_strap[SCO_F_GAIN]) begin
            sel_val.gain = strap_val.gain; // [RULE12]
        end
        if (use_strap[SCO_F_OCL]) begin
            sel_val.ocl = strap_val.ocl; // [RULE13]
        end
        if (use_strap[SCO_F_VOLTAGE_SELECT_STRAP]) begin
            sel_val.boot_voltage_code = strap_val.boot_voltage_code; // [RULE15]
        end
    end

endmodule : sco_select
`default_nettype wire

// file: logic/sco_top.sv
// Strap override configuration: override word register, power-up latch and selection.
// Summary of operation
// [RULE1] By default strap results take priority over stored values for every function.
// [RULE2] An override bit at one selects the stored value for its function.
// [RULE3] Host writes, stores to EEPROM and power-cycles before an override acts.
// [RULE4] Bit 15 at one disables all strap detection whatever the other bits hold.
// [RULE5] Bits 14 to 12 are read-only, read zero and ignore writes.
// [RULE6] Bit 11 set: stored soft-start value used until soft-start is written.
// [RULE7] Bit 10 set: stored fault responses used until fault responses are written.
// [RULE8] Bit 9 set: stored bus address used until the address is written.
// [RULE9] Bit 6 set: stored light-load mode used until the system word is written.
// [RULE10] Bit 5 set: stored switching frequency used until frequency is written.
// [RULE11] Bit 4 set: stored ramp setting used until compensation is written.
// [RULE12] Bit 3 set: stored gain setting used until compensation is written.
// [RULE13] Bit 2 set: stored current limit used until the limit is written.
// [RULE14] Bit 0 clear: voltage select from strap, unless an external divider is used.
// [RULE15] Bit 0 set: stored boot code and output voltage values until written.
// [RULE16] Boot code decodes through a fixed table into the DAC target.
// [RULE17] Override word is written and read as a word and backed in EEPROM.
// [RULE18] Positions 8, 7 and 1 always read zero.
// [RULE19] Stored word is latched once at power-up and steers selection thereafter.
`timescale 1ns/1ps
`default_nettype none
module sco_top
    import sco_pkg::*;
(
    // Clock and reset.
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Decoded management bus word transactions.
    input  wire logic [7:0]           cmd_code,
    input  wire logic                 wr_word_stb,
    input  wire logic [15:0]          wr_data,
    input  wire logic                 rd_word_stb,
    output logic                      wr_ack,
    output logic                      rd_valid,
    output logic      [15:0]          rd_data,
    // Restore from and store to EEPROM.
    input  wire logic                 nvm_restore_stb,
    input  wire logic [15:0]          nvm_word,
    output logic      [15:0]          store_word,
    // Strap results and stored function values.
    input  wire sco_func_t            strap_val,
    input  wire sco_func_t            nvm_val,
    input  wire logic                 ext_divider,
    input  wire logic [SCO_NFUNC-1:0] func_written_stb,
    // Selected configuration.
    output logic                      cfg_valid,
    output logic      [SCO_NFUNC-1:0] sel_strap,
    output sco_func_t                 func_sel,
    output logic      [11:0]          boot_dac_voltage
);

    sco_state_t           state_reg, state_next;
    logic [15:0]          live_reg, live_next;
    logic [15:0]          latched_reg, latched_next;
    logic [SCO_NFUNC-1:0] written_reg, written_next;
    logic                 wr_ack_next, rd_valid_next;
    logic [15:0]          rd_data_reg, rd_data_next;
    logic                 cfg_valid_reg, cfg_valid_next;
    logic [SCO_NFUNC-1:0] sel_strap_reg, sel_strap_next;
    sco_func_t            func_sel_reg, func_sel_next;
    logic [11:0]          boot_dac_reg, boot_dac_next;
    logic                 wr_ack_reg, rd_valid_reg;

    logic                 cmd_hit;
    sco_func_t            sel_val;
    logic [SCO_NFUNC-1:0] use_strap;
    logic [11:0]          dac_lookup;

    assign cmd_hit = (cmd_code == SCO_CMD_OVERRIDE);

    // Source selection works only from the latched copy, never the live word.
    sco_select u_select (
        .ovr_word    (latched_reg),
        .written     (written_reg),
        .ext_divider (ext_divider),
        .strap_val   (strap_val),
        .nvm_val     (nvm_val),
        .sel_val     (sel_val),
        .use_strap   (use_strap)
    );

    sco_boot_decode u_decode (
        .boot_voltage_code (sel_val.boot_voltage_code),
        .boot_dac_voltage  (dac_lookup)
    );

    // Power-up sequencing: wait for the restore, then hold the selection.
    always_comb begin
        state_next   = state_reg;
        latched_next = latched_reg;
        case (state_reg)
            SCO_ST_WAIT: begin
                if (nvm_restore_stb) begin
                    latched_next = sco_keep_bits(nvm_word); // [RULE19]
                    state_next   = SCO_ST_RUN;
                end
            end
            SCO_ST_RUN: begin
                // Later restores and host writes leave the latched copy alone until a
                // fresh power cycle, so a write only acts after store and restart.
                latched_next = latched_reg; // [RULE3]
            end
            default: begin
                state_next   = SCO_ST_WAIT;
                latched_next = SCO_WORD_RESET;
            end
        endcase
    end

    // Live override word: restored once, then written by the host.
    always_comb begin
        live_next = live_reg;
        if (state_reg == SCO_ST_WAIT && nvm_restore_stb) begin
            live_next = sco_keep_bits(nvm_word);
        end
        // A host write in the restore cycle wins, as it is the newer value.
        if (wr_word_stb && cmd_hit) begin
            live_next = sco_keep_bits(wr_data); // [RULE5] [RULE17] [RULE18]
        end
    end

    // Word transaction answers, one cycle after the strobe.
    always_comb begin
        wr_ack_next   = wr_word_stb && cmd_hit;
        rd_valid_next = rd_word_stb && cmd_hit;
        rd_data_next  = rd_data_reg;
        if (rd_word_stb && cmd_hit) begin
            rd_data_next = sco_keep_bits(live_reg); // [RULE5] [RULE18]
        end
    end

    // Sticky record of functions rewritten since power-up; only reset clears it.
    always_comb begin
        written_next = written_reg | func_written_stb;
    end

    // Selected configuration, held at zero until the restore has been latched.
    always_comb begin
        cfg_valid_next = (state_reg == SCO_ST_RUN);
        sel_strap_next = '0;
        func_sel_next  = '0;
        boot_dac_next  = '0;
        if (state_reg == SCO_ST_RUN) begin
            sel_strap_next = use_strap;
            func_sel_next  = sel_val;
            boot_dac_next  = dac_lookup; // [RULE16]
        end
    end

    // Register stage for every group of state.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_reg     <= SCO_ST_WAIT;
            live_reg      <= SCO_WORD_RESET;
            latched_reg   <= SCO_WORD_RESET;
            written_reg   <= '0;
            wr_ack_reg    <= 1'b0;
            rd_valid_reg  <= 1'b0;
            rd_data_reg   <= SCO_WORD_RESET;
            cfg_valid_reg <= 1'b0;
            sel_strap_reg <= '0;
            func_sel_reg  <= '0;
            boot_dac_reg  <= '0;
        end else begin
            state_reg     <= state_next;
            live_reg      <= live_next;
            latched_reg   <= latched_next;
            written_reg   <= written_next;
            wr_ack_reg    <= wr_ack_next;
            rd_valid_reg  <= rd_valid_next;
            rd_data_reg   <= rd_data_next;
            cfg_valid_reg <= cfg_valid_next;
            sel_strap_reg <= sel_strap_next;
            func_sel_reg  <= func_sel_next;
            boot_dac_reg  <= boot_dac_next;
        end
    end

    // Outputs straight from flip-flops; store_word feeds the EEPROM store engine.
    assign wr_ack           = wr_ack_reg;
    assign rd_valid         = rd_valid_reg;
    assign rd_data          = rd_data_reg;
    assign store_word       = live_reg;
    assign cfg_valid        = cfg_valid_reg;
    assign sel_strap        = sel_strap_reg;
    assign func_sel         = func_sel_reg;
    assign boot_dac_voltage = boot_dac_reg;

    // Checks on the behaviour above.

    default_ok_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE1]
        cfg_valid_reg && $past(latched_reg == 16'h0000 && written_reg == '0 && !ext_divider)
        |-> sel_strap_reg == 9'h1ff)
        else $error("Strap results lost priority with no override set.");

    bypass_src_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE2]
        cfg_valid_reg && latched_reg[SCO_POS_SS] && !$past(written_reg[SCO_F_SS])
        |-> func_sel_reg.ton_rise == $past(nvm_val.ton_rise))
        else $error("Bypassed function did not take the stored value.");

    latch_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE3]
        state_reg == SCO_ST_RUN && wr_word_stb && cmd_hit |=> $stable(latched_reg))
        else $error("Host write changed the active selection without a power cycle.");

    global_off_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE4]
        cfg_valid_reg && latched_reg[SCO_POS_GLOBAL] |-> sel_strap_reg == 9'h000)
        else $error("Strap detection still active under the global bypass.");

    rd_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE5]
        rd_valid_reg |-> rd_data_reg[14:12] == 3'b000)
        else $error("Read-only bits 14 to 12 read nonzero.");

    ss_bypass_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE6]
        cfg_valid_reg && latched_reg[SCO_POS_SS] |-> !sel_strap_reg[SCO_F_SS])
        else $error("Soft-start strap used while bypassed.");

    fault_bypass_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE7]
        cfg_valid_reg && latched_reg[SCO_POS_FAULT] |-> !sel_strap_reg[SCO_F_FAULT])
        else $error("Fault response strap used while bypassed.");

    addr_bypass_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE8]
        cfg_valid_reg && latched_reg[SCO_POS_ADDR] |-> !sel_strap_reg[SCO_F_ADDR])
        else $error("Bus address strap used while bypassed.");

    mode_bypass_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE9]
        cfg_valid_reg && latched_reg[SCO_POS_MODE] |-> !sel_strap_reg[SCO_F_MODE])
        else $error("Light-load strap used while bypassed.");

    fsw_bypass_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE10]
        cfg_valid_reg && latched_reg[SCO_POS_FSW] |-> !sel_strap_reg[SCO_F_FSW])
        else $error("Frequency strap used while bypassed.");

    ramp_bypass_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE11]
        cfg_valid_reg && latched_reg[SCO_POS_RAMP] |-> !sel_strap_reg[SCO_F_RAMP])
        else $error("Ramp strap used while bypassed.");

    gain_bypass_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE12]
        cfg_valid_reg && latched_reg[SCO_POS_GAIN] |-> !sel_strap_reg[SCO_F_GAIN])
        else $error("Gain strap used while bypassed.");

    ocl_bypass_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE13]
        cfg_valid_reg && latched_reg[SCO_POS_OCL] |-> !sel_strap_reg[SCO_F_OCL])
        else $error("Current limit strap used while bypassed.");

    ext_div_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE14]
        cfg_valid_reg && $past(ext_divider) |-> !sel_strap_reg[SCO_F_VOLTAGE_SELECT_STRAP])
        else $error("Voltage strap used with an external divider.");

    voltage_select_strap_stored_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE15]
        cfg_valid_reg && latched_reg[SCO_POS_VOLTAGE_SELECT_STRAP] && !$past(written_reg[SCO_F_VOLTAGE_SELECT_STRAP])
        |-> func_sel_reg.boot_voltage_code == $past(nvm_val.boot_voltage_code))
        else $error("Stored boot code not used under the voltage bypass.");

    boot_mid_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE16]
        state_reg == SCO_ST_RUN && sel_val.boot_voltage_code == 5'h11
        |=> boot_dac_reg == 12'h800)
        else $error("Boot code 10001 did not decode to 0.5 V.");

    boot_top_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE16]
        state_reg == SCO_ST_RUN && sel_val.boot_voltage_code == 5'h1f
        |=> boot_dac_reg == 12'hc00)
        else $error("Boot code 11111 did not decode to 0.75 V.");

    wr_echo_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE17]
        wr_word_stb && cmd_hit ##1 rd_word_stb && cmd_hit && !wr_word_stb
        |=> rd_valid_reg && rd_data_reg == ($past(wr_data, 2) & 16'h8e7d))
        else $error("Read word did not return the written override word.");

    rsvd_zero_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE18]
        rd_valid_reg |-> rd_data_reg[8:7] == 2'b00 && !rd_data_reg[1])
        else $error("Unsupported positions 8, 7 or 1 read nonzero.");

    latch_once_a: assert property (@(posedge clk) disable iff (!rst_b) // [RULE19]
        state_reg == SCO_ST_WAIT && nvm_restore_stb
        |=> latched_reg == ($past(nvm_word) & 16'h8e7d) && state_reg == SCO_ST_RUN
            ##1 $stable(latched_reg))
        else $error("Override word not latched once at restore.");

endmodule : sco_top
`default_nettype wire

// file: test/sco_host_model.sv
// Far-side model: EEPROM backing of the override word and the power-up restore.
`timescale 1ns/1ps
`default_nettype none
module sco_host_model
    import sco_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Store request and the live word to store.
    input  wire logic        store_req,
    input  wire logic [15:0] store_word,
    // Restore toward the device.
    output logic             nvm_restore_stb,
    output logic      [15:0] nvm_word
);
    logic [15:0] eeprom_reg = 16'h0000;
    logic        restored_reg = 1'b0;

    // Store captures the word; one restore follows each release of reset.
    always @(posedge clk) begin
        if (store_req) begin
            eeprom_reg <= store_word;
        end
        nvm_restore_stb <= rst_b && !restored_reg;
        restored_reg    <= rst_b;
    end

    // Outside the restore pulse the data is not held, so show its inverse.
    assign nvm_word = nvm_restore_stb ? eeprom_reg : ~eeprom_reg;
endmodule : sco_host_model
`default_nettype wire

// file: test/sco_top_bench.sv
// Self-checking testbench of the strap override configuration block.
`timescale 1ns/1ps
`default_nettype none
module sco_top_bench;
    import sco_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, wr_word_stb = 1'b0, rd_word_stb = 1'b0;
    logic ext_divider = 1'b0, store_req = 1'b0, nvm_restore_stb, wr_ack, rd_valid, cfg_valid;
    logic [7:0] cmd_code = 8'h00;
    logic [15:0] wr_data = 16'h0000, rd_data, nvm_word, store_word;
    logic [SCO_NFUNC-1:0] func_written_stb = '0, sel_strap, mask;
    sco_func_t strap_val = '1, nvm_val = '0, func_sel;
    logic [11:0] boot_dac_voltage;
    int fail_count = 0, num_checks = 0;
    int pos [10] = '{15, 11, 10, 9, 6, 5, 4, 3, 2, 0};

    sco_top u_sco_top (.clk(clk), .rst_b(rst_b), .cmd_code(cmd_code), .wr_word_stb(wr_word_stb),
        .wr_data(wr_data), .rd_word_stb(rd_word_stb), .wr_ack(wr_ack), .rd_valid(rd_valid),
        .rd_data(rd_data), .nvm_restore_stb(nvm_restore_stb), .nvm_word(nvm_word),
        .store_word(store_word), .strap_val(strap_val), .nvm_val(nvm_val),
        .ext_divider(ext_divider), .func_written_stb(func_written_stb), .cfg_valid(cfg_valid),
        .sel_strap(sel_strap), .func_sel(func_sel), .boot_dac_voltage(boot_dac_voltage));
    sco_host_model u_sco_host_model (.clk(clk), .rst_b(rst_b), .store_req(store_req),
        .store_word(store_word), .nvm_restore_stb(nvm_restore_stb), .nvm_word(nvm_word));

    // Clock of 5 ns period.
    always #2.5 clk = ~clk;

    task automatic print_verdict;
        if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // Word write; the answer is looked at in the cycle after the taking edge.
    task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ack);
        @(posedge clk);
        cmd_code <= c; wr_word_stb <= 1'b1; wr_data <= d;
        @(posedge clk);
        wr_word_stb <= 1'b0;
        #1 chk(wr_ack, ack);
    endtask : wr

    task automatic rd(input logic [7:0] c, input logic [15:0] d, input logic ok);
        @(posedge clk);
        cmd_code <= c; rd_word_stb <= 1'b1;
        @(posedge clk);
        rd_word_stb <= 1'b0;
        #1 chk(rd_valid, ok);
        if (ok) chk(rd_data, d);
    endtask : rd

    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    // Reset for three cycles, then wait a bounded time for the restored selection.
    task automatic power_up;
        int n;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        for (n = 0; n < 20 && cfg_valid !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
    endtask : power_up

    // Write the word, store it, power-cycle, and read back the restored copy.
    task automatic pwr(input logic [15:0] w);
        wr(8'hd8, w, 1'b1);
        @(posedge clk);
        store_req <= 1'b1;
        @(posedge clk);
        store_req <= 1'b0;
        power_up();
        rd(8'hd8, w & 16'h8e7d, 1'b1);
    endtask : pwr

    function automatic logic [8:0] exp_sel(input logic [15:0] w, input logic [8:0] wn);
        logic [8:0] b;
        b = {w[0], w[2], w[3], w[4], w[5], w[6], w[9], w[10], w[11]};
        return w[15] ? 9'h000 : (~b & ~wn & {~ext_divider, 8'hff});
    endfunction : exp_sel

    // Each selected field comes from the strap side where its select bit is set.
    task automatic check_cfg(input logic [8:0] s);
        sco_func_t r;
        r = nvm_val;
        if (s[0]) r.ton_rise = strap_val.ton_rise;
        if (s[1]) r.fault_resp = strap_val.fault_resp;
        if (s[2]) r.bus_addr = strap_val.bus_addr;
        if (s[3]) r.light_load = strap_val.light_load;
        if (s[4]) r.fsw = strap_val.fsw;
        if (s[5]) r.ramp = strap_val.ramp;
        if (s[6]) r.gain = strap_val.gain;
        if (s[7]) r.ocl = strap_val.ocl;
        if (s[8]) r.boot_voltage_code = strap_val.boot_voltage_code;
        chk(cfg_valid, 1'b1);
        chk(sel_strap, s);
        chk(func_sel, r);
        chk(boot_dac_voltage, SCO_BOOT_DAC_TBL[r.boot_voltage_code]);
    endtask : check_cfg

    // Watchdog against a hang.
    initial begin
        #200000;
        fail_count++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        repeat (2) @(posedge clk);
        #1 chk(cfg_valid, 1'b0);
        chk(store_word, 16'h0000);
        power_up();
        check_cfg(9'h1ff);
        ext_divider <= 1'b1;
        settle();
        check_cfg(9'h0ff);
        ext_divider <= 1'b0;
        wr(8'hd8, 16'hffff, 1'b1);
        rd(8'hd8, 16'h8e7d, 1'b1);
        wr(8'h61, 16'h0000, 1'b0);
        rd(8'h61, 16'h0000, 1'b0);
        rd(8'hd8, 16'h8e7d, 1'b1);
        // A read right after a write sees the new word.
        @(posedge clk);
        wr_word_stb <= 1'b1; cmd_code <= 8'hd8; wr_data <= 16'h0001;
        @(posedge clk);
        wr_word_stb <= 1'b0; rd_word_stb <= 1'b1;
        @(posedge clk);
        rd_word_stb <= 1'b0;
        #1 chk(rd_data, 16'h0001);
        settle();
        check_cfg(9'h1ff);
        for (int i = 0; i < 10; i++) begin
            pwr(16'h0001 << pos[i]);
            check_cfg(exp_sel(16'h0001 << pos[i], 9'h000));
        end
        // Written functions leave the strap side and stay there.
        pwr(16'h0000);
        mask = '0;
        for (int f = 0; f < SCO_NFUNC; f++) begin
            func_written_stb <= 9'h001 << f;
            @(posedge clk);
            func_written_stb <= '0;
            mask[f] = 1'b1;
            settle();
            check_cfg(exp_sel(16'h0000, mask));
        end
        pwr(16'h8000);
        for (int c = 0; c < 32; c++) begin
            nvm_val.boot_voltage_code <= c[4:0];
            settle();
            check_cfg(9'h000);
        end
        chk(boot_dac_voltage, 12'hc00);
        nvm_val.boot_voltage_code <= 5'h11;
        settle();
        chk(boot_dac_voltage, 12'h800);
        print_verdict();
    end
endmodule : sco_top_bench
`default_nettype wire
